//--- rtl/pmrs_pkg.sv
// Constants of the PHY management register set
package pmrs_pkg;
    // Number of PHY ports served
    localparam int NUM_PORTS = 2;
    // PHY select addresses
    localparam logic [4:0] PHY_ADDR_PORT1 = 5'h01;
    localparam logic [4:0] PHY_ADDR_PORT2 = 5'h02;
    // Register indexes
    localparam logic [4:0] REG_ID_LOW = 5'h03;
    localparam logic [4:0] REG_AN_ADV = 5'h04;
    localparam logic [4:0] REG_LP_ABILITY = 5'h05;
    localparam logic [4:0] REG_CABLE_DIAG = 5'h1D;
    localparam logic [4:0] REG_SPECIAL = 5'h1F;
    // Ability field positions
    localparam int ABIL_PAUSE_BIT = 10;
    localparam int ABIL_RSVD_BIT = 9;
    localparam int ABIL_100F_BIT = 8;
    localparam int ABIL_100H_BIT = 7;
    localparam int ABIL_10F_BIT = 6;
    localparam int ABIL_10H_BIT = 5;
    // Cable diagnostic field positions
    localparam int DIAG_START_BIT = 15;
    localparam int DIAG_RESULT_LSB = 13;
    localparam int DIAG_NEAR_BIT = 12;
    // Special control/status field positions
    localparam int SPC_POLRVS_BIT = 5;
    localparam int SPC_MDIX_BIT = 4;
    localparam int SPC_FORCE_LINK_BIT = 3;
    localparam int SPC_PWRSAVE_N_BIT = 2;
    localparam int SPC_RLOOP_BIT = 1;
    localparam int SPC_RSVD_BIT = 0;
    // Reset values
    localparam logic ADV_ABILITY_RST = 1'h1;
    localparam logic ADV_RSVD_RST = 1'h0;
    localparam logic [4:0] ADV_SELECTOR = 5'h01;
    localparam logic FORCE_LINK_RST = 1'h0;
    localparam logic PWRSAVE_N_RST = 1'h1;
    localparam logic RLOOP_RST = 1'h0;
    localparam logic SPC_RSVD_RST = 1'h0;
    localparam logic [1:0] CT_RESULT_RST = 2'h0;
    localparam logic [8:0] CT_COUNT_RST = 9'h000;
    // Management frame layout
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [3:0] HDR_LAST = 4'hB;
    localparam logic [3:0] DATA_LAST = 4'hF;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
endpackage

//--- rtl/pmrs_ct_if.sv
// Register engine to cable test sequencer link
`timescale 1ns/1ps
`default_nettype none
interface pmrs_ct_if;
    logic start_req; // One-cycle request to start a test
    logic busy; // Test running, reads as the start bit
    logic [1:0] result; // Captured result code
    logic near_short; // Short closer than ten metres
    logic [8:0] fault_count; // Distance to fault
    modport ctrl (output start_req, input busy, result, near_short,
        fault_count);
    modport engine (input start_req, output busy, result, near_short,
        fault_count);
endinterface
`default_nettype wire

//--- rtl/pmrs_mdc_edge.sv
// Management clock edge finder and data sampler
`timescale 1ns/1ps
`default_nettype none
module pmrs_mdc_edge
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Management pins
    input wire logic mdc,
    input wire logic mdio_in,
    // Aligned rising edge and sampled bit
    output logic mdc_rise,
    output logic mdio_bit
);
    logic mdc_prev_ff; // Management clock one cycle ago
    logic rise_ff; // Registered rising edge
    logic bit_ff; // Data bit sampled with the edge

    // Edge and bit are both delayed one cycle so they stay aligned
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mdc_prev_ff <= 1'h0;
            rise_ff <= 1'h0;
            bit_ff <= 1'h1;
        end
        else
        begin
            mdc_prev_ff <= mdc;
            rise_ff <= mdc & ~mdc_prev_ff;
            bit_ff <= mdio_in;
        end
    end

    assign mdc_rise = rise_ff;
    assign mdio_bit = bit_ff;
endmodule
`default_nettype wire

//--- rtl/pmrs_cable_test.sv
// Cable test sequencer for one port
`timescale 1ns/1ps
`default_nettype none
module pmrs_cable_test
    import pmrs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register engine side
    pmrs_ct_if.engine ct,
    // Analog test engine side
    output logic test_start,
    input wire logic test_done,
    input wire logic [1:0] test_result,
    input wire logic test_near,
    input wire logic [8:0] test_count
);
    logic busy_ff; // Test in progress
    logic start_ff; // Start pulse to the analog side
    logic [1:0] result_ff; // Last result code
    logic near_ff; // Last near short flag
    logic [8:0] count_ff; // Last fault distance

    // Start only when idle; a done while idle is stray and ignored
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_ff <= 1'h0;
            start_ff <= 1'h0;
        end
        else
        begin
            start_ff <= ct.start_req & ~busy_ff;
            if (ct.start_req && !busy_ff)
                busy_ff <= 1'h1;
            else if (test_done)
                busy_ff <= 1'h0;
        end
    end

    // Results captured only when a running test ends
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_ff <= CT_RESULT_RST;
            near_ff <= 1'h0;
            count_ff <= CT_COUNT_RST;
        end
        else if (busy_ff && test_done)
        begin
            result_ff <= test_result;
            near_ff <= test_near;
            count_ff <= test_count;
        end
    end

    assign test_start = start_ff;
    assign ct.busy = busy_ff;
    assign ct.result = result_ff;
    assign ct.near_short = near_ff;
    assign ct.fault_count = count_ff;
endmodule
`default_nettype wire

//--- rtl/pmrs_top.sv
// Management register set of two PHYs behind a serial management port
//
// How it works
// - PHY address 1 and 2 select ports
// - Fixed read-only low identifier at index 3
// - Pause advertisement bit 10, default one
// - 100 Mbps full/half advertisement flags, default one
// - 10 Mbps full/half advertisement flags, default one
// - Partner pause report, read live from LP_PAUSE
// - Partner 100 Mbps abilities reported, default zero
// - Partner 10 Mbps abilities reported, default zero
// - Start bit launches test, clears when done
// - Result code field, default normal
// - Near short flag below ten metres
// - Nine-bit fault distance, default zero
// - Reversed polarity flag, default zero
// - Inverted power-save control, default one
// - Remote loopback control, default zero
`timescale 1ns/1ps
`default_nettype none
module pmrs_top
#(
    // Low identifier word; value is arbitrary
    parameter logic [15:0] PHY_ID_LOW = 16'hA5C3
)
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // Serial management port
    input wire logic MDC,
    input wire logic MDIO_IN,
    output logic MDIO_OUT,
    output logic MDIO_OE_N,
    // Advertised abilities, one bit per port
    output logic [pmrs_pkg::NUM_PORTS-1:0] ADV_PAUSE,
    output logic [pmrs_pkg::NUM_PORTS-1:0] ADV_100_FULL,
    output logic [pmrs_pkg::NUM_PORTS-1:0] ADV_100_HALF,
    output logic [pmrs_pkg::NUM_PORTS-1:0] ADV_10_FULL,
    output logic [pmrs_pkg::NUM_PORTS-1:0] ADV_10_HALF,
    // Partner abilities from negotiation
    input wire logic [pmrs_pkg::NUM_PORTS-1:0] LP_PAUSE,
    input wire logic [pmrs_pkg::NUM_PORTS-1:0] LP_100_FULL,
    input wire logic [pmrs_pkg::NUM_PORTS-1:0] LP_100_HALF,
    input wire logic [pmrs_pkg::NUM_PORTS-1:0] LP_10_FULL,
    input wire logic [pmrs_pkg::NUM_PORTS-1:0] LP_10_HALF,
    // Line state from the PHYs
    input wire logic [pmrs_pkg::NUM_PORTS-1:0] POLARITY_REVERSED,
    input wire logic [pmrs_pkg::NUM_PORTS-1:0] MDIX_ACTIVE,
    // PHY controls
    output logic [pmrs_pkg::NUM_PORTS-1:0] FORCE_LINK,
    output logic [pmrs_pkg::NUM_PORTS-1:0] POWER_SAVE_OFF,
    output logic [pmrs_pkg::NUM_PORTS-1:0] REMOTE_LOOPBACK,
    // Cable test engines
    output logic [pmrs_pkg::NUM_PORTS-1:0] CABLE_TEST_START,
    input wire logic [pmrs_pkg::NUM_PORTS-1:0] CABLE_TEST_DONE,
    input wire logic [2*pmrs_pkg::NUM_PORTS-1:0] CABLE_RESULT,
    input wire logic [pmrs_pkg::NUM_PORTS-1:0] CABLE_NEAR_SHORT,
    input wire logic [9*pmrs_pkg::NUM_PORTS-1:0] CABLE_FAULT_COUNT
);
    import pmrs_pkg::*;

    // Frame sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_HDR,
        ST_TA,
        ST_DATA
    } pmrs_state_t;

    logic mdc_rise; // One-cycle pulse per management clock rise
    logic mdio_bit; // Data bit aligned with mdc_rise
    pmrs_state_t state_ff; // Frame position
    pmrs_state_t nxt_state; // Next frame position
    logic [3:0] bit_cnt_ff; // Bit count inside a field
    logic [5:0] pre_cnt_ff; // Consecutive preamble ones, saturating
    logic [10:0] hdr_shift_ff; // Header bits collected so far
    logic [1:0] hdr_op_ff; // Captured opcode
    logic [4:0] hdr_phy_ff; // Captured phy_select_address
    logic [4:0] hdr_reg_ff; // Captured phy_register_index
    logic [14:0] wr_shift_ff; // Write data collected so far
    logic [15:0] rd_shift_ff; // Read data being sent
    logic mdio_out_ff; // Driven data bit
    logic mdio_oe_n_ff; // Low while we drive the line
    logic hdr_hit; // Header names one of our PHYs
    logic hdr_port; // Port picked by the header
    logic wr_stb; // Commit of a write frame
    logic [15:0] wr_data; // Complete write word
    logic [NUM_PORTS-1:0] adv_rsvd_ff; // Spare writable adv bit
    logic [NUM_PORTS-1:0] spc_rsvd_ff; // Spare writable special bit
    logic [NUM_PORTS-1:0] adv_pause_ff; // Pause advertised
    logic [NUM_PORTS-1:0] adv_100f_ff; // 100 full advertised
    logic [NUM_PORTS-1:0] adv_100h_ff; // 100 half advertised
    logic [NUM_PORTS-1:0] adv_10f_ff; // 10 full advertised
    logic [NUM_PORTS-1:0] adv_10h_ff; // 10 half advertised
    logic [NUM_PORTS-1:0] force_link_ff; // Forced link pass
    logic [NUM_PORTS-1:0] pwrsave_n_ff; // Power saving disabled when set
    logic [NUM_PORTS-1:0] rloop_ff; // Remote loopback enabled
    logic [NUM_PORTS-1:0] ct_busy; // Test running per port
    logic [1:0] ct_result [NUM_PORTS]; // Result code per port
    logic [NUM_PORTS-1:0] ct_near; // Near short per port
    logic [8:0] ct_count [NUM_PORTS]; // Fault distance per port

    // Port index from a PHY address; only valid under a hit
    function automatic logic port_of(input logic [4:0] phy);
        port_of = (phy == PHY_ADDR_PORT2);
    endfunction

    // True when the PHY address belongs to this device
    function automatic logic phy_hit(input logic [4:0] phy);
        phy_hit = (phy == PHY_ADDR_PORT1) || (phy == PHY_ADDR_PORT2);
    endfunction

    // Read word of one port; unsupported indexes answer zero
    function automatic logic [15:0] read_word(input logic p,
        input logic [4:0] ra);
        logic [15:0] w;
        w = 16'h0000;
        case (ra)
            REG_ID_LOW:
                w = PHY_ID_LOW;
            REG_AN_ADV:
            begin
                w[ABIL_PAUSE_BIT] = adv_pause_ff[p];
                w[ABIL_RSVD_BIT] = adv_rsvd_ff[p];
                w[ABIL_100F_BIT] = adv_100f_ff[p];
                w[ABIL_100H_BIT] = adv_100h_ff[p];
                w[ABIL_10F_BIT] = adv_10f_ff[p];
                w[ABIL_10H_BIT] = adv_10h_ff[p];
                w[4:0] = ADV_SELECTOR;
            end
            REG_LP_ABILITY:
            begin
                w[ABIL_PAUSE_BIT] = LP_PAUSE[p];
                w[ABIL_100F_BIT] = LP_100_FULL[p];
                w[ABIL_100H_BIT] = LP_100_HALF[p];
                w[ABIL_10F_BIT] = LP_10_FULL[p];
                w[ABIL_10H_BIT] = LP_10_HALF[p];
            end
            REG_CABLE_DIAG:
            begin
                w[DIAG_START_BIT] = ct_busy[p];
                w[DIAG_RESULT_LSB +: 2] = ct_result[p];
                w[DIAG_NEAR_BIT] = ct_near[p];
                w[8:0] = ct_count[p];
            end
            REG_SPECIAL:
            begin
                w[SPC_POLRVS_BIT] = POLARITY_REVERSED[p];
                w[SPC_MDIX_BIT] = MDIX_ACTIVE[p];
                w[SPC_FORCE_LINK_BIT] = force_link_ff[p];
                w[SPC_PWRSAVE_N_BIT] = pwrsave_n_ff[p];
                w[SPC_RLOOP_BIT] = rloop_ff[p];
                w[SPC_RSVD_BIT] = spc_rsvd_ff[p];
            end
            default:
                w = 16'h0000;
        endcase
        read_word = w;
    endfunction

    // Edge finder on the management clock
    pmrs_mdc_edge u_edge (
        .clk(CLOCK),
        .rst_n(RESETN),
        .mdc(MDC),
        .mdio_in(MDIO_IN),
        .mdc_rise(mdc_rise),
        .mdio_bit(mdio_bit)
    );

    // Header decode for drive and write paths
    assign hdr_hit = phy_hit(hdr_phy_ff);
    assign hdr_port = port_of(hdr_phy_ff);

    // Write commits on the last data bit
    assign wr_stb = mdc_rise && (state_ff == ST_DATA) &&
        (bit_cnt_ff == DATA_LAST) && (hdr_op_ff == OP_WRITE) && hdr_hit;
    assign wr_data = {wr_shift_ff, mdio_bit};

    // Next frame position, moved on management clock rises
    always_comb
    begin
        nxt_state = state_ff;
        if (mdc_rise)
        begin
            case (state_ff)
                ST_IDLE:
                    // A zero after a full preamble is the first start bit
                    if (!mdio_bit && pre_cnt_ff == PREAMBLE_LEN)
                        nxt_state = ST_START;
                ST_START:
                    nxt_state = mdio_bit ? ST_HDR : ST_IDLE;
                ST_HDR:
                    if (bit_cnt_ff == HDR_LAST)
                        nxt_state = ST_TA;
                ST_TA:
                    if (bit_cnt_ff[0])
                        nxt_state = ST_DATA;
                ST_DATA:
                    if (bit_cnt_ff == DATA_LAST)
                        nxt_state = ST_IDLE;
                default:
                    nxt_state = ST_IDLE;
            endcase
        end
    end

    // Frame position and field bit counter
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (mdc_rise)
            begin
                // Counter restarts whenever the field changes
                if (nxt_state != state_ff)
                    bit_cnt_ff <= 4'h0;
                else
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
        end
    end

    // Preamble ones, counted only between frames
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            pre_cnt_ff <= 6'h00;
        else if (mdc_rise)
        begin
            if (state_ff != ST_IDLE || !mdio_bit)
                pre_cnt_ff <= 6'h00;
            else if (pre_cnt_ff != PREAMBLE_LEN)
                pre_cnt_ff <= pre_cnt_ff + 6'h01;
        end
    end

    // Opcode, PHY and register index collection
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            hdr_shift_ff <= 11'h000;
            hdr_op_ff <= 2'h0;
            hdr_phy_ff <= 5'h00;
            hdr_reg_ff <= 5'h00;
        end
        else if (mdc_rise && state_ff == ST_HDR)
        begin
            hdr_shift_ff <= {hdr_shift_ff[9:0], mdio_bit};
            if (bit_cnt_ff == HDR_LAST)
                {hdr_op_ff, hdr_phy_ff, hdr_reg_ff} <=
                    {hdr_shift_ff, mdio_bit};
        end
    end

    // Write data collection; host turnaround bits are not checked
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            wr_shift_ff <= 15'h0000;
        else if (mdc_rise && state_ff == ST_DATA)
            wr_shift_ff <= {wr_shift_ff[13:0], mdio_bit};
    end

    // Line driver: zero in second turnaround bit, then 16 data bits
    // Bits change about two cycles after a rise, well before the next
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            mdio_out_ff <= 1'h0;
            mdio_oe_n_ff <= 1'h1;
            rd_shift_ff <= 16'h0000;
        end
        else if (mdc_rise)
        begin
            case (state_ff)
                ST_TA:
                    if (!bit_cnt_ff[0])
                    begin
                        // Foreign addresses and writes leave the line alone
                        if (hdr_op_ff == OP_READ && hdr_hit)
                        begin
                            mdio_oe_n_ff <= 1'h0;
                            mdio_out_ff <= 1'h0;
                            rd_shift_ff <= read_word(hdr_port, hdr_reg_ff);
                        end
                    end
                    else
                    begin
                        mdio_out_ff <= rd_shift_ff[15];
                        rd_shift_ff <= {rd_shift_ff[14:0], 1'h0};
                    end
                ST_DATA:
                    if (bit_cnt_ff == DATA_LAST)
                    begin
                        mdio_oe_n_ff <= 1'h1;
                        mdio_out_ff <= 1'h0;
                    end
                    else
                    begin
                        mdio_out_ff <= rd_shift_ff[15];
                        rd_shift_ff <= {rd_shift_ff[14:0], 1'h0};
                    end
                default:
                begin
                    mdio_oe_n_ff <= 1'h1;
                    mdio_out_ff <= 1'h0;
                end
            endcase
        end
    end

    // Advertisement word
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            adv_pause_ff <= {NUM_PORTS{ADV_ABILITY_RST}};
            adv_rsvd_ff <= {NUM_PORTS{ADV_RSVD_RST}};
            adv_100f_ff <= {NUM_PORTS{ADV_ABILITY_RST}};
            adv_100h_ff <= {NUM_PORTS{ADV_ABILITY_RST}};
            adv_10f_ff <= {NUM_PORTS{ADV_ABILITY_RST}};
            adv_10h_ff <= {NUM_PORTS{ADV_ABILITY_RST}};
        end
        else if (wr_stb && hdr_reg_ff == REG_AN_ADV)
        begin
            adv_pause_ff[hdr_port] <= wr_data[ABIL_PAUSE_BIT];
            adv_rsvd_ff[hdr_port] <= wr_data[ABIL_RSVD_BIT];
            adv_100f_ff[hdr_port] <= wr_data[ABIL_100F_BIT];
            adv_100h_ff[hdr_port] <= wr_data[ABIL_100H_BIT];
            adv_10f_ff[hdr_port] <= wr_data[ABIL_10F_BIT];
            adv_10h_ff[hdr_port] <= wr_data[ABIL_10H_BIT];
        end
    end

    // Special control word; status bits there are live inputs
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            force_link_ff <= {NUM_PORTS{FORCE_LINK_RST}};
            pwrsave_n_ff <= {NUM_PORTS{PWRSAVE_N_RST}};
            rloop_ff <= {NUM_PORTS{RLOOP_RST}};
            spc_rsvd_ff <= {NUM_PORTS{SPC_RSVD_RST}};
        end
        else if (wr_stb && hdr_reg_ff == REG_SPECIAL)
        begin
            force_link_ff[hdr_port] <= wr_data[SPC_FORCE_LINK_BIT];
            pwrsave_n_ff[hdr_port] <= wr_data[SPC_PWRSAVE_N_BIT];
            rloop_ff[hdr_port] <= wr_data[SPC_RLOOP_BIT];
            // Stored as written so a careless host can see its slip
            spc_rsvd_ff[hdr_port] <= wr_data[SPC_RSVD_BIT];
        end
    end

    // One cable test sequencer per port
    pmrs_ct_if ct_bus [NUM_PORTS] ();
    for (genvar g = 0; g < NUM_PORTS; g++)
    begin : g_port
        // Only a one in the start bit requests a test
        assign ct_bus[g].start_req = wr_stb && (hdr_port == g[0]) &&
            (hdr_reg_ff == REG_CABLE_DIAG) && wr_data[DIAG_START_BIT];
        assign ct_busy[g] = ct_bus[g].busy;
        assign ct_result[g] = ct_bus[g].result;
        assign ct_near[g] = ct_bus[g].near_short;
        assign ct_count[g] = ct_bus[g].fault_count;

        pmrs_cable_test u_ct (
            .clk(CLOCK),
            .rst_n(RESETN),
            .ct(ct_bus[g]),
            .test_start(CABLE_TEST_START[g]),
            .test_done(CABLE_TEST_DONE[g]),
            .test_result(CABLE_RESULT[2*g +: 2]),
            .test_near(CABLE_NEAR_SHORT[g]),
            .test_count(CABLE_FAULT_COUNT[9*g +: 9])
        );
    end

    // Outputs from the control flops
    assign MDIO_OUT = mdio_out_ff;
    assign MDIO_OE_N = mdio_oe_n_ff;
    assign ADV_PAUSE = adv_pause_ff;
    assign ADV_100_FULL = adv_100f_ff;
    assign ADV_100_HALF = adv_100h_ff;
    assign ADV_10_FULL = adv_10f_ff;
    assign ADV_10_HALF = adv_10h_ff;
    assign FORCE_LINK = force_link_ff;
    assign POWER_SAVE_OFF = pwrsave_n_ff;
    assign REMOTE_LOOPBACK = rloop_ff;
endmodule
`default_nettype wire

//--- tb/pmrs_monitor.sv
// Port checker for the register set
`timescale 1ns/1ps
`default_nettype none
module pmrs_monitor
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // Watched outputs
    input wire logic MDIO_OUT,
    input wire logic MDIO_OE_N,
    input wire logic [1:0] ADV_PAUSE,
    input wire logic [1:0] ADV_100_FULL,
    input wire logic [1:0] POWER_SAVE_OFF,
    input wire logic [1:0] REMOTE_LOOPBACK,
    input wire logic [1:0] CABLE_TEST_START
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    // Read drive spans at least nine clock cycles
    sequence s_hold;
        !MDIO_OE_N [*8];
    endsequence
    a_drive_span: assert property ($fell(MDIO_OE_N) |->
        !MDIO_OUT ##1 s_hold) else $error("read drive cut short");
    a_adv_reset: assert property ($rose(RESETN) |->
        &{ADV_PAUSE, ADV_100_FULL}) else $error("advert wrong after reset");
    a_ctrl_reset: assert property ($rose(RESETN) |->
        POWER_SAVE_OFF == 2'h3 && REMOTE_LOOPBACK == 2'h0 && MDIO_OE_N)
        else $error("controls wrong after reset");
    a_start_pulse: assert property (CABLE_TEST_START[0] |=>
        !CABLE_TEST_START[0] [*2]) else $error("start not a single pulse");
    a_start_on_write: assert property (|CABLE_TEST_START |-> MDIO_OE_N)
        else $error("test start during a read");
    a_adv_on_write: assert property (!$stable(ADV_PAUSE) |->
        $past(MDIO_OE_N)) else $error("pause moved outside a write");
    a_full_on_write: assert property (!$stable(ADV_100_FULL) |->
        MDIO_OE_N) else $error("100 full moved outside a write");
    a_loop_on_write: assert property (!$stable(REMOTE_LOOPBACK) |->
        MDIO_OE_N) else $error("loopback moved outside a write");
endmodule
bind pmrs_top pmrs_monitor pmrs_monitor_i (.CLOCK(CLOCK), .RESETN(RESETN),
    .MDIO_OUT(MDIO_OUT), .MDIO_OE_N(MDIO_OE_N), .ADV_PAUSE(ADV_PAUSE),
    .ADV_100_FULL(ADV_100_FULL), .POWER_SAVE_OFF(POWER_SAVE_OFF),
    .REMOTE_LOOPBACK(REMOTE_LOOPBACK), .CABLE_TEST_START(CABLE_TEST_START));
`default_nettype wire

//--- tb/pmrs_host.sv
// Management host model for the serial port
`timescale 1ns/1ps
`default_nettype none
module pmrs_host
(
    // Clock
    input wire logic clk,
    // Serial pins
    output logic mdc,
    output logic mdio,
    input wire logic oe_n,
    input wire logic dout
);
    logic drv = 1'b1; // Host level, pull-up when released
    // Device wins while enabled, else host or pull-up
    assign mdio = oe_n ? drv : dout;
    initial
        mdc = 1'b0;
    // Preamble, start, op, addresses, turnaround, data; MSB first
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
        input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--)
        begin
            @(posedge clk);
            mdc <= 1'b0;
            // Released for turnaround and data of a read
            drv <= (op == 2'h2 && i < 18) ? 1'b1 : f[i];
            repeat (3) @(posedge clk);
            mdc <= 1'b1;
            // Bit stands at our rising edge
            if (i < 16)
                rd[i] = mdio;
            repeat (2) @(posedge clk);
        end
        // Let a write commit
        repeat (5) @(posedge clk);
        drv <= 1'b1;
    endtask
endmodule
`default_nettype wire

//--- tb/pmrs_top_test.sv
// Bench for the PHY management register set
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module pmrs_top_test;
    import pmrs_pkg::*;
    localparam logic [15:0] ID = 16'h3C5A; // Value is arbitrary
    int checks = 0, bad_count = 0, pulses = 0;
    logic clk = 1'b0, rst_n = 1'b0, mdc, mdio, oe_n, dout;
    logic [1:0] ap, af, ah, tf, th, fl, pso, rl, cts, done = '0, near = '0;
    logic [9:0] lp = '0; // Partner abilities
    logic [3:0] ls = '0, res = '0; // Line state and test results
    logic [17:0] cnt = '0;
    pmrs_top #(.PHY_ID_LOW(ID)) pmrs_top_i (.CLOCK(clk), .RESETN(rst_n),
        .MDC(mdc), .MDIO_IN(mdio), .MDIO_OUT(dout), .MDIO_OE_N(oe_n),
        .ADV_PAUSE(ap), .ADV_100_FULL(af), .ADV_100_HALF(ah),
        .ADV_10_FULL(tf), .ADV_10_HALF(th), .LP_PAUSE(lp[9:8]),
        .LP_100_FULL(lp[7:6]), .LP_100_HALF(lp[5:4]), .LP_10_FULL(lp[3:2]),
        .LP_10_HALF(lp[1:0]), .POLARITY_REVERSED(ls[3:2]),
        .MDIX_ACTIVE(ls[1:0]), .FORCE_LINK(fl), .POWER_SAVE_OFF(pso),
        .REMOTE_LOOPBACK(rl), .CABLE_TEST_START(cts), .CABLE_TEST_DONE(done),
        .CABLE_RESULT(res), .CABLE_NEAR_SHORT(near), .CABLE_FAULT_COUNT(cnt));
    pmrs_host pmrs_host_i (.clk(clk), .mdc(mdc), .mdio(mdio), .oe_n(oe_n),
        .dout(dout));
    // 40 MHz clock
    initial
        forever #12.5 clk = ~clk;
    // Start pulses of port 1
    always @(posedge clk)
        if (cts[0] === 1'b1)
            pulses++;
    task automatic wx(input logic [4:0] p, r, input logic [15:0] d);
        logic [15:0] q;
        pmrs_host_i.xfer(OP_WRITE, p, r, d, q);
    endtask
    task automatic rx(input logic [4:0] p, r, input logic [15:0] w);
        logic [15:0] q;
        pmrs_host_i.xfer(OP_READ, p, r, 16'h0000, q);
        `CHK(q, w)
    endtask
    task automatic t_defaults;
        for (logic [4:0] p = 5'h01; p <= 5'h02; p++)
        begin
            rx(p, REG_ID_LOW, ID);
            rx(p, REG_AN_ADV, 16'h05E1);
            rx(p, REG_LP_ABILITY, 16'h0000);
            rx(p, REG_CABLE_DIAG, 16'h0000);
            rx(p, REG_SPECIAL, 16'h0004);
        end
        `CHK({ap, pso, rl}, 6'h3C)
        $display("t_defaults done");
    endtask
    task automatic t_adv;
        wx(PHY_ADDR_PORT1, REG_AN_ADV, 16'h0000);
        `CHK({ap, af, ah, tf, th}, 10'h2AA)
        rx(PHY_ADDR_PORT1, REG_AN_ADV, 16'h0001);
        wx(PHY_ADDR_PORT1, REG_AN_ADV, 16'hFFFF);
        rx(PHY_ADDR_PORT1, REG_AN_ADV, 16'h07E1);
        wx(PHY_ADDR_PORT2, REG_ID_LOW, 16'h0000);
        rx(PHY_ADDR_PORT2, REG_ID_LOW, ID);
        wx(5'h03, REG_AN_ADV, 16'h0000);
        `CHK(th, 2'h3)
        $display("t_adv done");
    endtask
    task automatic t_status;
        lp <= 10'h2AA;
        ls <= 4'hA;
        rx(PHY_ADDR_PORT2, REG_LP_ABILITY, 16'h05E0);
        rx(PHY_ADDR_PORT1, REG_LP_ABILITY, 16'h0000);
        wx(PHY_ADDR_PORT2, REG_LP_ABILITY, 16'h0000);
        rx(PHY_ADDR_PORT2, REG_LP_ABILITY, 16'h05E0);
        rx(PHY_ADDR_PORT2, REG_SPECIAL, 16'h0034);
        rx(5'h03, REG_ID_LOW, 16'hFFFF);
        rx(PHY_ADDR_PORT1, 5'h00, 16'h0000);
        lp <= 10'h000;
        ls <= 4'h0;
        $display("t_status done");
    endtask
    task automatic t_special;
        wx(PHY_ADDR_PORT2, REG_SPECIAL, 16'h000A);
        `CHK({fl, pso, rl}, 6'h26)
        rx(PHY_ADDR_PORT2, REG_SPECIAL, 16'h000A);
        $display("t_special done");
    endtask
    task automatic t_cable;
        logic [15:0] w = 16'h0000;
        for (int c = 0; c < 4; c++)
        begin
            wx(PHY_ADDR_PORT1, REG_CABLE_DIAG, 16'h8000);
            wx(PHY_ADDR_PORT1, REG_CABLE_DIAG, 16'h8000);
            `CHK(pulses, c + 1)
            rx(PHY_ADDR_PORT1, REG_CABLE_DIAG, w | 16'h8000);
            w = {1'b0, c[1:0], c[0], 3'h0, c[1:0], 7'h55};
            res[1:0] <= c[1:0];
            near[0] <= c[0];
            cnt[8:0] <= {c[1:0], 7'h55};
            done[0] <= 1'b1;
            @(posedge clk);
            done[0] <= 1'b0;
            rx(PHY_ADDR_PORT1, REG_CABLE_DIAG, w);
        end
        $display("t_cable done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        summarize();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_defaults();
        t_adv();
        t_status();
        t_special();
        t_cable();
        summarize();
    end
endmodule
`default_nettype wire
